// ==== common/mcu_exec_pkg.sv ====
// shared constants and types for the instruction execution unit
package mcu_exec_pkg;
  // datapath and storage sizes
  localparam int DATA_W = 8;
  localparam int PC_W = 10;
  localparam int MEM_AW = 6;
  localparam int STACK_DEPTH = 2;
  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFS_INSTR = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_MAIN = 6'h08;
  localparam logic [5:0] OFS_PC = 6'h0C;
  localparam logic [5:0] OFS_WDOG = 6'h10;
  localparam logic [5:0] OFS_MEMPTR = 6'h14;
  localparam logic [5:0] OFS_MEMDATA = 6'h18;
  localparam logic [5:0] OFS_STACK = 6'h1C;
  // ==========================================================
  // instruction word and status field positions
  localparam int OP_LSB = 24;
  localparam int TGT_LSB = 8;
  localparam int IMM_LSB = 0;
  localparam int ST_SW_W = 5;
  localparam int ST_HALTED = 7;
  localparam int ST_PRE_ONE = 8;
  localparam int ST_PRE_TWO = 9;
  localparam int ST_ILLEGAL = 10;
  // ==========================================================
  // reset values and arithmetic constants
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [7:0] WDOG_CLR = 8'h00;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  // watchdog timing
  localparam int WDOG_DIV = 256;
  localparam int WDOG_W = 8;
  // ==========================================================
  // operation codes of the instruction register
  typedef enum logic [4:0] {
    OP_IDLE = 5'h00, OP_PRECLEAR_ONE = 5'h01, OP_PRECLEAR_TWO = 5'h02,
    OP_INVERT_MEM = 5'h03, OP_INVERT_TO_MAIN = 5'h04,
    OP_BCD_FIXUP = 5'h05, OP_MEM_MINUS_ONE = 5'h06,
    OP_MINUS_ONE_TO_MAIN = 5'h07, OP_MEM_PLUS_ONE = 5'h08,
    OP_PLUS_ONE_TO_MAIN = 5'h09, OP_HALT = 5'h0A, OP_JUMP = 5'h0B,
    OP_COPY_IMM = 5'h0C, OP_COPY_TO_MEM = 5'h0D, OP_COPY_TO_MAIN = 5'h0E,
    OP_UNION_MEM = 5'h0F, OP_UNION_IMM = 5'h10, OP_UNION_TO_MEM = 5'h11,
    OP_SUB_EXIT = 5'h12, OP_SUB_EXIT_LOAD = 5'h13, OP_IRQ_EXIT = 5'h14,
    OP_ROT_MEM = 5'h15, OP_ROT_TO_MAIN = 5'h16
  } op_e;
  typedef struct packed {
    op_e op;
    logic [PC_W-1:0] target;
    logic [DATA_W-1:0] imm;
  } instr_s;
  // flag order puts zero at bit 0 of the status word
  typedef struct packed {
    logic sleep;
    logic timeout;
    logic irqEnable;
    logic signedWrap;
    logic halfCarry;
    logic carry;
    logic zero;
  } flags_s;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_EXEC2 = 2'b01, S_DONE = 2'b10
  } state_e;
endpackage

// ==== logic/mcu_exec_unit.sv ====
// instruction execution unit with avalon register port
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Contract
// - preclear pair clears watchdog, timeout, sleep
// - lone preclear only records itself
// - invert memory byte, update zero only
// - inverted byte to main, memory kept
// - low nibble over nine or half-carry: add six
// - high nibble fixup sets carry, result to memory
// - decrement byte, zero flag only
// - increment byte, zero flag only
// - halt stops execution and watchdog clock
// - halt clears watchdog, sets sleep, advances
// - jump loads target, no flag change
// - immediate constant into main, no flags
// - copies between main and memory, no flags
// - idle op only advances program counter
// - union into main updates zero only
// - union back to memory, zero only
// - subroutine exit pops stack in two cycles
// - exit with load also sets main
// - interrupt exit pops and enables interrupts
// - rotate memory left, bit seven wraps
// - rotated byte to main, nothing else
module mcu_exec_unit #(
  parameter int WDOG_DIV = mcu_exec_pkg::WDOG_DIV
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wakeReq,
  output logic haltedOut
);
  localparam int PC_W = mcu_exec_pkg::PC_W;
  localparam int AW = mcu_exec_pkg::MEM_AW;
  localparam int DEPTH = mcu_exec_pkg::STACK_DEPTH;
  localparam int WW = mcu_exec_pkg::WDOG_W;
  mcu_exec_pkg::state_e stateQ;
  mcu_exec_pkg::flags_s flagsQ, flagsD;
  mcu_exec_pkg::instr_s instr;
  logic [7:0] mainQ, mainD;
  logic [PC_W-1:0] pcQ, pcD;
  logic [PC_W-1:0] stackQ [DEPTH];
  logic [1:0] depthQ;
  logic [7:0] dataMem [1 << AW];
  logic [AW-1:0] memPtrQ;
  logic [7:0] memRd, memWrData;
  logic mainWe, memWe, popStack, twoCycle;
  logic preOneQ, preTwoQ, preOneD, preTwoD;
  logic haltedQ, illegalQ, illegalD, haltNow, pairDone;
  logic wakeS1Q, wakeS2Q;
  logic [31:0] readDataQ, readMux;
  logic busWr, execNow, wdogExpire;
  logic [WW-1:0] wdogCount;

  // ==========================================================
  // bus handshake
  // instruction fields come straight from the held write data
  assign instr = {avs_writedata[mcu_exec_pkg::OP_LSB +: 5],
                  avs_writedata[mcu_exec_pkg::TGT_LSB +: PC_W],
                  avs_writedata[mcu_exec_pkg::IMM_LSB +: 8]};
  assign twoCycle = (instr.op == mcu_exec_pkg::OP_SUB_EXIT) ||
                    (instr.op == mcu_exec_pkg::OP_SUB_EXIT_LOAD) ||
                    (instr.op == mcu_exec_pkg::OP_IRQ_EXIT);
  assign busWr = (stateQ == mcu_exec_pkg::S_DONE) && avs_write;
  // a halted core ignores instruction writes
  assign execNow = busWr && (avs_address == mcu_exec_pkg::OFS_INSTR) &&
                   (&avs_byteenable) && !haltedQ;
  assign avs_waitrequest = (stateQ != mcu_exec_pkg::S_DONE);
  assign avs_readdata = readDataQ;
  assign haltedOut = haltedQ;

  // access sequencer: idle, optional second cycle, done
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= mcu_exec_pkg::S_IDLE;
    end else begin
      case (stateQ)
        mcu_exec_pkg::S_IDLE: begin
          if (avs_write && avs_address == mcu_exec_pkg::OFS_INSTR &&
              twoCycle && !haltedQ) begin
            stateQ <= mcu_exec_pkg::S_EXEC2;
          end else if (avs_read || avs_write) begin
            stateQ <= mcu_exec_pkg::S_DONE;
          end
        end
        mcu_exec_pkg::S_EXEC2: stateQ <= mcu_exec_pkg::S_DONE;
        mcu_exec_pkg::S_DONE: stateQ <= mcu_exec_pkg::S_IDLE;
        default: stateQ <= mcu_exec_pkg::S_IDLE;
      endcase
    end
  end

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    readMux = 32'h0000_0000;
    case (avs_address)
      mcu_exec_pkg::OFS_STATUS: begin
        readMux[6:0] = flagsQ;
        readMux[mcu_exec_pkg::ST_HALTED] = haltedQ;
        readMux[mcu_exec_pkg::ST_PRE_ONE] = preOneQ;
        readMux[mcu_exec_pkg::ST_PRE_TWO] = preTwoQ;
        readMux[mcu_exec_pkg::ST_ILLEGAL] = illegalQ;
      end
      mcu_exec_pkg::OFS_MAIN: readMux[7:0] = mainQ;
      mcu_exec_pkg::OFS_PC: readMux[PC_W-1:0] = pcQ;
      mcu_exec_pkg::OFS_WDOG: readMux[WW-1:0] = wdogCount;
      mcu_exec_pkg::OFS_MEMPTR: readMux[AW-1:0] = memPtrQ;
      mcu_exec_pkg::OFS_MEMDATA: readMux[7:0] = dataMem[memPtrQ];
      mcu_exec_pkg::OFS_STACK: readMux[1:0] = depthQ;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // read data captured on the first cycle, held through done
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      readDataQ <= 32'h0000_0000;
    end else if (stateQ == mcu_exec_pkg::S_IDLE && avs_read) begin
      readDataQ <= readMux;
    end
  end

  // ==========================================================
  // instruction datapath
  assign memRd = dataMem[instr.target[AW-1:0]];

  // result, destination and flag effects of each operation
  always_comb begin
    logic [4:0] loSum;
    logic [4:0] hiSum;
    logic [3:0] hiIn;
    logic [7:0] res;
    loSum = 5'h00;
    hiSum = 5'h00;
    hiIn = 4'h0;
    res = 8'h00;
    flagsD = flagsQ;
    mainD = mainQ;
    mainWe = 1'b0;
    memWe = 1'b0;
    memWrData = memRd;
    pcD = pcQ + 1'b1;
    popStack = 1'b0;
    preOneD = preOneQ;
    preTwoD = preTwoQ;
    pairDone = 1'b0;
    haltNow = 1'b0;
    illegalD = 1'b0;
    case (instr.op)
      mcu_exec_pkg::OP_IDLE: res = 8'h00;
      mcu_exec_pkg::OP_PRECLEAR_ONE: begin
        if (preTwoQ) begin
          pairDone = 1'b1;
          preTwoD = 1'b0;
          preOneD = 1'b0;
        end else begin
          preOneD = 1'b1;
        end
      end
      mcu_exec_pkg::OP_PRECLEAR_TWO: begin
        if (preOneQ) begin
          pairDone = 1'b1;
          preTwoD = 1'b0;
          preOneD = 1'b0;
        end else begin
          preTwoD = 1'b1;
        end
      end
      mcu_exec_pkg::OP_INVERT_MEM: begin
        res = ~memRd;
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_INVERT_TO_MAIN: begin
        res = ~memRd;
        mainWe = 1'b1;
      end
      mcu_exec_pkg::OP_BCD_FIXUP: begin
        loSum = {1'b0, mainQ[3:0]};
        if (mainQ[3:0] > mcu_exec_pkg::BCD_LIMIT || flagsQ.halfCarry) begin
          loSum = {1'b0, mainQ[3:0]} + {1'b0, mcu_exec_pkg::BCD_FIX};
        end
        hiSum = {1'b0, mainQ[7:4]} + {4'h0, loSum[4]};
        hiIn = mainQ[7:4];
        if (hiSum > {1'b0, mcu_exec_pkg::BCD_LIMIT} || flagsQ.carry) begin
          hiIn = hiSum[3:0] + mcu_exec_pkg::BCD_FIX;
          flagsD.carry = 1'b1;
        end else begin
          hiIn = hiSum[3:0];
        end
        memWrData = {hiIn, loSum[3:0]};
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_MEM_MINUS_ONE: begin
        res = memRd - 8'h01;
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_MINUS_ONE_TO_MAIN: begin
        res = memRd - 8'h01;
        mainWe = 1'b1;
      end
      mcu_exec_pkg::OP_MEM_PLUS_ONE: begin
        res = memRd + 8'h01;
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_PLUS_ONE_TO_MAIN: begin
        res = memRd + 8'h01;
        mainWe = 1'b1;
      end
      mcu_exec_pkg::OP_HALT: begin
        haltNow = 1'b1;
        flagsD.sleep = 1'b1;
        flagsD.timeout = 1'b0;
      end
      mcu_exec_pkg::OP_JUMP: pcD = instr.target;
      mcu_exec_pkg::OP_COPY_IMM: begin
        mainD = instr.imm;
      end
      mcu_exec_pkg::OP_COPY_TO_MEM: begin
        memWrData = mainQ;
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_COPY_TO_MAIN: mainD = memRd;
      mcu_exec_pkg::OP_UNION_MEM: begin
        res = mainQ | memRd;
        mainWe = 1'b1;
      end
      mcu_exec_pkg::OP_UNION_IMM: begin
        res = mainQ | instr.imm;
        mainWe = 1'b1;
      end
      mcu_exec_pkg::OP_UNION_TO_MEM: begin
        res = mainQ | memRd;
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_SUB_EXIT: begin
        pcD = stackQ[0];
        popStack = 1'b1;
      end
      mcu_exec_pkg::OP_SUB_EXIT_LOAD: begin
        pcD = stackQ[0];
        popStack = 1'b1;
        mainD = instr.imm;
      end
      mcu_exec_pkg::OP_IRQ_EXIT: begin
        pcD = stackQ[0];
        popStack = 1'b1;
        flagsD.irqEnable = 1'b1;
      end
      mcu_exec_pkg::OP_ROT_MEM: begin
        memWrData = {memRd[6:0], memRd[7]};
        memWe = 1'b1;
      end
      mcu_exec_pkg::OP_ROT_TO_MAIN: begin
        mainD = {memRd[6:0], memRd[7]};
      end
      default: illegalD = 1'b1;
    endcase
    // zero-flag users write res and take zero from it
    if (mainWe) begin
      mainD = res;
    end
    if (mainWe || instr.op == mcu_exec_pkg::OP_INVERT_MEM ||
        instr.op == mcu_exec_pkg::OP_MEM_MINUS_ONE ||
        instr.op == mcu_exec_pkg::OP_MEM_PLUS_ONE ||
        instr.op == mcu_exec_pkg::OP_UNION_TO_MEM) begin
      flagsD.zero = (res == 8'h00);
    end
    if (instr.op == mcu_exec_pkg::OP_INVERT_MEM ||
        instr.op == mcu_exec_pkg::OP_MEM_MINUS_ONE ||
        instr.op == mcu_exec_pkg::OP_MEM_PLUS_ONE ||
        instr.op == mcu_exec_pkg::OP_UNION_TO_MEM) begin
      memWrData = res;
    end
  end

  // ==========================================================
  // architectural state
  // main register: instruction result or direct bus write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mainQ <= mcu_exec_pkg::MAIN_RST;
    end else if (execNow) begin
      mainQ <= mainD;
    end else if (busWr && avs_address == mcu_exec_pkg::OFS_MAIN &&
                 avs_byteenable[0]) begin
      mainQ <= avs_writedata[7:0];
    end
  end

  // flags: watchdog expiry wins over any clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flagsQ <= '0;
    end else begin
      if (execNow) begin
        flagsQ <= flagsD;
        if (pairDone) begin
          flagsQ.timeout <= 1'b0;
          flagsQ.sleep <= 1'b0;
        end
      end else if (busWr && avs_address == mcu_exec_pkg::OFS_STATUS &&
                   avs_byteenable[0]) begin
        flagsQ[mcu_exec_pkg::ST_SW_W-1:0] <=
          avs_writedata[mcu_exec_pkg::ST_SW_W-1:0];
      end
      if (wdogExpire) begin
        flagsQ.timeout <= 1'b1;
      end
    end
  end

  // program counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pcQ <= mcu_exec_pkg::PC_RST;
    end else if (execNow) begin
      pcQ <= pcD;
    end else if (busWr && avs_address == mcu_exec_pkg::OFS_PC) begin
      pcQ <= avs_writedata[PC_W-1:0];
    end
  end

  // return stack: bus writes push, returns pop; entry 0 is the top
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      depthQ <= 2'b00;
      for (int i = 0; i < DEPTH; i++) begin
        stackQ[i] <= mcu_exec_pkg::PC_RST;
      end
    end else if (execNow && popStack) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        stackQ[i] <= stackQ[i+1];
      end
      if (depthQ != 2'b00) begin
        depthQ <= depthQ - 1'b1;
      end
    end else if (busWr && avs_address == mcu_exec_pkg::OFS_STACK) begin
      stackQ[0] <= avs_writedata[PC_W-1:0];
      for (int i = 1; i < DEPTH; i++) begin
        stackQ[i] <= stackQ[i-1];
      end
      if (depthQ != 2'(DEPTH)) begin
        depthQ <= depthQ + 1'b1;
      end
    end
  end

  // data memory: instruction write-back or bus write at the pointer
  always_ff @(posedge mclk) begin
    if (execNow && memWe) begin
      dataMem[instr.target[AW-1:0]] <= memWrData;
    end else if (busWr && avs_address == mcu_exec_pkg::OFS_MEMDATA &&
                 avs_byteenable[0]) begin
      dataMem[memPtrQ] <= avs_writedata[7:0];
    end
  end

  // memory pointer for bus access
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      memPtrQ <= '0;
    end else if (busWr && avs_address == mcu_exec_pkg::OFS_MEMPTR) begin
      memPtrQ <= avs_writedata[AW-1:0];
    end
  end

  // preclear memory and unknown-operation flag
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      preOneQ <= 1'b0;
      preTwoQ <= 1'b0;
      illegalQ <= 1'b0;
    end else if (execNow) begin
      preOneQ <= preOneD;
      preTwoQ <= preTwoD;
      illegalQ <= illegalD;
    end
  end

  // wake pin synchroniser
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeS1Q <= 1'b0;
      wakeS2Q <= 1'b0;
    end else begin
      wakeS1Q <= wakeReq;
      wakeS2Q <= wakeS1Q;
    end
  end

  // halted state: entering wins over a wake in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      haltedQ <= 1'b0;
    end else if (execNow && haltNow) begin
      haltedQ <= 1'b1;
    end else if (wakeS2Q) begin
      haltedQ <= 1'b0;
    end
  end

  // ==========================================================
  // watchdog: frozen while halted, cleared by pair or halt
  watchdog_timer #(
    .DIV_CYCLES(WDOG_DIV),
    .COUNT_W(WW)
  ) u_wdog (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(!haltedQ),
    .clear(execNow && (pairDone || haltNow)),
    .count(wdogCount),
    .expire(wdogExpire)
  );

  // ==========================================================
  // assertions
  property p_pair_clear;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && pairDone) |=> (wdogCount == '0 && !flagsQ.timeout &&
      !flagsQ.sleep && !preOneQ && !preTwoQ);
  endproperty
  a_pair_clear: assert property (p_pair_clear)
    else $error("preclear pair did not clear watchdog and flags");

  property p_lone_preclear;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_PRECLEAR_ONE && !preTwoQ)
      |=> (preOneQ && $stable(flagsQ.sleep));
  endproperty
  a_lone_preclear: assert property (p_lone_preclear)
    else $error("lone preclear changed state");

  property p_halt;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_HALT) |=> (haltedQ &&
      flagsQ.sleep && pcQ == $past(pcQ) + 1'b1 && wdogCount == '0);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt effects wrong");

  property p_jump;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_JUMP)
      |=> (pcQ == $past(instr.target) && $stable(flagsQ[4:0]));
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump did not load target");

  property p_copy_imm;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_COPY_IMM)
      |=> (mainQ == $past(instr.imm) && $stable(flagsQ.zero));
  endproperty
  a_copy_imm: assert property (p_copy_imm)
    else $error("immediate copy wrong");

  property p_union_zero;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_UNION_IMM)
      |=> (flagsQ.zero == (mainQ == 8'h00));
  endproperty
  a_union_zero: assert property (p_union_zero)
    else $error("zero flag disagrees with result");

  property p_exit_two;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_SUB_EXIT)
      |-> ($past(stateQ) == mcu_exec_pkg::S_EXEC2) ##1
          (pcQ == $past(stackQ[0]));
  endproperty
  a_exit_two: assert property (p_exit_two)
    else $error("subroutine exit timing or target wrong");

  property p_irq_exit;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_IRQ_EXIT)
      |=> (flagsQ.irqEnable && $stable(flagsQ.carry));
  endproperty
  a_irq_exit: assert property (p_irq_exit)
    else $error("interrupt exit did not enable interrupts");

  property p_idle;
    @(posedge mclk) disable iff (sys_rst)
    (execNow && instr.op == mcu_exec_pkg::OP_IDLE)
      |=> (pcQ == $past(pcQ) + 1'b1 && $stable(mainQ));
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle op changed state");
endmodule // mcu_exec_unit

// ==== logic/watchdog_timer.sv ====
// watchdog prescaler and counter
`timescale 1ns/1ns
module watchdog_timer #(
  parameter int DIV_CYCLES = mcu_exec_pkg::WDOG_DIV,
  parameter int COUNT_W = mcu_exec_pkg::WDOG_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic clear,
  output logic [COUNT_W-1:0] count,
  output logic expire
);
  // ==========================================================
  // elaboration check
  generate
    if (DIV_CYCLES < 1 || COUNT_W < 2) begin : g_bad
      $error("watchdog_timer: unsupported parameters");
    end
  endgenerate
  localparam int PW = (DIV_CYCLES > 1) ? $clog2(DIV_CYCLES) : 1;
  localparam logic [PW-1:0] DIV_LAST = PW'(DIV_CYCLES - 1);
  logic [PW-1:0] preQ;
  logic tick;
  logic [COUNT_W-1:0] countQ;
  logic expireQ;
  assign tick = run && (preQ == DIV_LAST);
  // prescaler: one enable pulse every DIV_CYCLES running cycles
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      preQ <= '0;
    end else if (clear || tick) begin
      preQ <= '0;
    end else if (run) begin
      preQ <= preQ + 1'b1;
    end
  end
  // counter: clear beats tick, wrap gives the expire pulse
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      countQ <= '0;
      expireQ <= 1'b0;
    end else begin
      expireQ <= 1'b0;
      if (clear) begin
        countQ <= '0;
      end else if (tick) begin
        countQ <= countQ + 1'b1;
        expireQ <= &countQ;
      end
    end
  end
  assign count = countQ;
  assign expire = expireQ;
endmodule // watchdog_timer

// ==== test/testbench.sv ====
// self-checking bench for the instruction execution unit
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wakeReq = 1'b0;
  logic haltedOut;
  int errorCnt = 0;
  int checksDone = 0;
  int waits;
  int w0;
  logic [31:0] rdv;
  logic [31:0] s;
  // short prescaler keeps watchdog activity visible
  mcu_exec_unit #(.WDOG_DIV(2)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wakeReq(wakeReq),
    .haltedOut(haltedOut));
  // free-running system clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  // ==========================================================
  // shared helpers
  task automatic complete_run();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one access held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [5:0] a,
                     input logic [31:0] d);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    waits = 0;
    do begin
      @(posedge mclk);
      waits++;
    end while (avs_waitrequest !== 1'b0 && waits < 50);
    rdv = avs_readdata;
    if (waits >= 50) begin
      errorCnt++;
      $display("unexpected at %0t: no answer", $time);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic ex(input mcu_exec_pkg::op_e op, input logic [9:0] t,
                    input logic [7:0] i);
    bus(1'b0, mcu_exec_pkg::OFS_INSTR, {3'h0, op, 6'h00, t, i});
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b1, a, 32'h00000000);
  endtask
  task automatic setm(input logic [5:0] a, input logic [7:0] v);
    bus(1'b0, mcu_exec_pkg::OFS_MEMPTR, {26'h0, a});
    bus(1'b0, mcu_exec_pkg::OFS_MEMDATA, {24'h0, v});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_mem();
    bus(1'b0, mcu_exec_pkg::OFS_STATUS, 32'h0000001E);
    setm(6'h05, 8'h80);
    ex(mcu_exec_pkg::OP_ROT_MEM, 10'h005, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'h01);
    ex(mcu_exec_pkg::OP_INVERT_MEM, 10'h005, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'hFE);
    setm(6'h05, 8'hFF);
    ex(mcu_exec_pkg::OP_MEM_PLUS_ONE, 10'h005, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[4:0], 5'h1F);
    ex(mcu_exec_pkg::OP_MEM_MINUS_ONE, 10'h005, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'hFF);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[4:0], 5'h1E);
    ex(mcu_exec_pkg::OP_ROT_MEM, 10'h005, 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[4:0], 5'h1E);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'hFF);
  endtask
  task automatic t_main();
    ex(mcu_exec_pkg::OP_COPY_IMM, 10'h000, 8'h3C);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h3C);
    setm(6'h09, 8'h81);
    ex(mcu_exec_pkg::OP_INVERT_TO_MAIN, 10'h009, 8'h00);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h7E);
    ex(mcu_exec_pkg::OP_ROT_TO_MAIN, 10'h009, 8'h00);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h03);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'h81);
    ex(mcu_exec_pkg::OP_UNION_IMM, 10'h000, 8'h40);
    ex(mcu_exec_pkg::OP_UNION_TO_MEM, 10'h009, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'hC3);
    ex(mcu_exec_pkg::OP_COPY_TO_MEM, 10'h009, 8'h00);
    ex(mcu_exec_pkg::OP_MINUS_ONE_TO_MAIN, 10'h009, 8'h00);
    ex(mcu_exec_pkg::OP_PLUS_ONE_TO_MAIN, 10'h009, 8'h00);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h44);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'h43);
    ex(mcu_exec_pkg::OP_COPY_TO_MAIN, 10'h009, 8'h00);
    ex(mcu_exec_pkg::OP_UNION_MEM, 10'h009, 8'h00);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h43);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[4:0], 5'h1E);
  endtask
  task automatic t_bcd();
    bus(1'b0, mcu_exec_pkg::OFS_MEMPTR, 32'h00000003);
    bus(1'b0, mcu_exec_pkg::OFS_STATUS, 32'h00000000);
    bus(1'b0, mcu_exec_pkg::OFS_MAIN, 32'h0000009A);
    ex(mcu_exec_pkg::OP_BCD_FIXUP, 10'h003, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[4:0], 5'h02);
    bus(1'b0, mcu_exec_pkg::OFS_STATUS, 32'h00000004);
    bus(1'b0, mcu_exec_pkg::OFS_MAIN, 32'h00000045);
    ex(mcu_exec_pkg::OP_BCD_FIXUP, 10'h003, 8'h00);
    rd(mcu_exec_pkg::OFS_MEMDATA);
    chk(rdv[7:0], 8'h4B);
  endtask
  task automatic t_flow();
    ex(mcu_exec_pkg::OP_JUMP, 10'h2A5, 8'h00);
    rd(mcu_exec_pkg::OFS_PC);
    chk(rdv[9:0], 10'h2A5);
    ex(mcu_exec_pkg::OP_IDLE, 10'h000, 8'h00);
    w0 = waits;
    rd(mcu_exec_pkg::OFS_PC);
    chk(rdv[9:0], 10'h2A6);
    bus(1'b0, mcu_exec_pkg::OFS_STACK, 32'h00000123);
    ex(mcu_exec_pkg::OP_SUB_EXIT, 10'h000, 8'h00);
    chk(32'(waits), 32'(w0 + 1));
    rd(mcu_exec_pkg::OFS_PC);
    chk(rdv[9:0], 10'h123);
    bus(1'b0, mcu_exec_pkg::OFS_STACK, 32'h00000055);
    ex(mcu_exec_pkg::OP_SUB_EXIT_LOAD, 10'h000, 8'h77);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h77);
    bus(1'b0, mcu_exec_pkg::OFS_STATUS, 32'h00000000);
    bus(1'b0, mcu_exec_pkg::OFS_STACK, 32'h000001FF);
    ex(mcu_exec_pkg::OP_IRQ_EXIT, 10'h000, 8'h00);
    rd(mcu_exec_pkg::OFS_PC);
    chk(rdv[9:0], 10'h1FF);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[4:0], 5'h10);
  endtask
  task automatic t_wdog();
    rd(mcu_exec_pkg::OFS_STATUS);
    s = rdv;
    ex(mcu_exec_pkg::OP_PRECLEAR_ONE, 10'h000, 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk({rdv[8], rdv[6:5]}, {1'b1, s[6:5]});
    ex(mcu_exec_pkg::OP_PRECLEAR_TWO, 10'h000, 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[9:5], 5'h00);
    rd(mcu_exec_pkg::OFS_WDOG);
    chk(rdv[7:2], 6'h00);
    rd(mcu_exec_pkg::OFS_PC);
    s = rdv + 32'h1;
    ex(mcu_exec_pkg::OP_HALT, 10'h000, 8'h00);
    chk(haltedOut, 1'b1);
    ex(mcu_exec_pkg::OP_COPY_IMM, 10'h000, 8'h5A);
    rd(mcu_exec_pkg::OFS_MAIN);
    chk(rdv[7:0], 8'h77);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[6:5], 2'b10);
    rd(mcu_exec_pkg::OFS_WDOG);
    chk(rdv[7:0], 8'h00);
    rd(mcu_exec_pkg::OFS_PC);
    chk(rdv[9:0], s[9:0]);
    wakeReq <= 1'b1;
    repeat (6) @(posedge mclk);
    wakeReq <= 1'b0;
    chk(haltedOut, 1'b0);
    ex(mcu_exec_pkg::OP_PRECLEAR_TWO, 10'h000, 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk({rdv[9], rdv[6:5]}, 3'b110);
    ex(mcu_exec_pkg::OP_PRECLEAR_ONE, 10'h000, 8'h00);
    rd(mcu_exec_pkg::OFS_STATUS);
    chk(rdv[9:5], 5'h00);
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_mem();
    t_main();
    t_bcd();
    t_flow();
    t_wdog();
    complete_run();
  end
  initial begin
    #100000;
    errorCnt++;
    complete_run();
  end
endmodule // testbench
